// ---- core/cmd_resp_pkg.sv ----
/*
  package for the command-response status logic: response codes, command
  kinds, field positions and reset values of the status upper word.
  assumes a single device clock domain; serial pins are synchronised
  inside the block that uses this package.
*/
// Function
// - four-bit field reports previous frame's command
// - codes 0000b, 0111b, 1000b never produced
// - first frame after reset reads 1001b
// - correct nop after read reports 0101b
// - frame errors execute nop, report 1010b
// - non-nop after read runs nop, 1011b
// - lock bit: 1 locked, 0 unlocked, reset 0
// - clock bit: 0 internal, 1 external
// - mode bit: 0 active, 1 standby/power-down
package cmd_resp_pkg;
  localparam int STATUS_W = 16;
  localparam int RESP_LSB = 3;
  localparam int RESP_MSB = 6;
  localparam int LOCK_BIT = 2;
  localparam int CLOCK_BIT = 1;
  localparam int MODE_BIT = 0;
  localparam int FAULT_LSB = 7;
  localparam int FAULT_W = 9;

  // response codes
  localparam logic [3:0] RESP_NOP = 4'h1;
  localparam logic [3:0] RESP_LOCK = 4'h2;
  localparam logic [3:0] RESP_UNLOCK = 4'h3;
  localparam logic [3:0] RESP_READ = 4'h4;
  localparam logic [3:0] RESP_READ_DONE = 4'h5;
  localparam logic [3:0] RESP_WRITE = 4'h6;
  localparam logic [3:0] RESP_POWERUP = 4'h9;
  localparam logic [3:0] RESP_ERROR = 4'hA;
  localparam logic [3:0] RESP_READ_BAD = 4'hB;
  localparam logic [3:0] RESP_RESET = 4'hC;

  localparam logic [3:0] RESP_RESET_VAL = RESP_POWERUP;
  localparam logic LOCK_RESET_VAL = 1'b0;
  localparam logic [STATUS_W-1:0] SHIFT_RESET_VAL = 16'h0000;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_REG_READ = 3'b001,
    CMD_REG_WRITE = 3'b010,
    CMD_LOCK = 3'b011,
    CMD_UNLOCK = 3'b100,
    CMD_RESET = 3'b101
  } cmd_kind_e;
endpackage

// ---- core/cmd_resp_status.sv ----
/*
  command-response and state indication part of the status word: decides
  the response code at each frame end and shifts the status upper word
  out msb first on the serial output.
  assumes a frame decoder on clk_in reports the decoded command and any
  framing or checksum error during the frame; cs and sclk come from pins.
*/
module cmd_resp_status (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_kind_in,
  input wire logic timeout_err_in,
  input wire logic sclk_count_err_in,
  input wire logic cmd_crc_err_in,
  input wire logic data_crc_err_in,
  input wire logic ext_clock_in,
  input wire logic standby_in,
  input wire logic [cmd_resp_pkg::FAULT_W-1:0] fault_bits_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  output logic [cmd_resp_pkg::STATUS_W-1:0] status_word_out,
  output logic locked_out
);
  // codes the block must never latch nor shift out to the host
  function automatic logic code_reserved(input logic [3:0] code);
    return code == 4'h0 || code == 4'h7 || code == 4'h8;
  endfunction

  // elaboration checks on the package: the fields must tile the upper
  // word exactly, or a package edit could overlap two of them unseen
  if (cmd_resp_pkg::FAULT_LSB + cmd_resp_pkg::FAULT_W !=
      cmd_resp_pkg::STATUS_W) begin
    $error("fault field must end at the word msb");
  end
  if (cmd_resp_pkg::RESP_MSB - cmd_resp_pkg::RESP_LSB != 3) begin
    $error("response field must be four bits wide");
  end
  if (cmd_resp_pkg::RESP_MSB + 1 != cmd_resp_pkg::FAULT_LSB) begin
    $error("response field must sit just below the faults");
  end
  if (cmd_resp_pkg::LOCK_BIT + 1 != cmd_resp_pkg::RESP_LSB ||
      cmd_resp_pkg::CLOCK_BIT + 1 != cmd_resp_pkg::LOCK_BIT ||
      cmd_resp_pkg::MODE_BIT + 1 != cmd_resp_pkg::CLOCK_BIT) begin
    $error("state bits must fill the bottom of the word");
  end
  // every code the block can latch must be one the host may
  if (code_reserved(cmd_resp_pkg::RESP_NOP) ||
      code_reserved(cmd_resp_pkg::RESP_LOCK) ||
      code_reserved(cmd_resp_pkg::RESP_UNLOCK) ||
      code_reserved(cmd_resp_pkg::RESP_READ) ||
      code_reserved(cmd_resp_pkg::RESP_READ_DONE) ||
      code_reserved(cmd_resp_pkg::RESP_WRITE) ||
      code_reserved(cmd_resp_pkg::RESP_RESET_VAL) ||
      code_reserved(cmd_resp_pkg::RESP_ERROR) ||
      code_reserved(cmd_resp_pkg::RESP_READ_BAD) ||
      code_reserved(cmd_resp_pkg::RESP_RESET)) begin
    $error("a latched response uses a reserved code");
  end

  // pin synchronisers; only stage two is read by logic
  // they reset to the pins' idle levels so no false edge follows reset
  logic [1:0] cs_sync_r;
  logic [1:0] sclk_sync_r;
  logic cs_prev_r;
  logic sclk_prev_r;
  logic frame_start;
  logic frame_end;
  logic sclk_rise;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_sync_r <= 2'b11;
      sclk_sync_r <= 2'b00;
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], cs_n_in};
      sclk_sync_r <= {sclk_sync_r[0], sclk_in};
      cs_prev_r <= cs_sync_r[1];
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  assign frame_start = cs_prev_r & ~cs_sync_r[1];
  assign frame_end = ~cs_prev_r & cs_sync_r[1];
  assign sclk_rise = ~cs_sync_r[1] & ~sclk_prev_r & sclk_sync_r[1];

  // per-frame capture of the decoded command and error conditions
  logic cmd_seen_r;
  logic [2:0] cmd_r;
  logic err_r;
  logic err_any;

  // any framing or checksum fault turns the frame into a nop
  assign err_any = timeout_err_in | sclk_count_err_in | cmd_crc_err_in |
                   data_crc_err_in;

  // an event in the frame start cycle beats the clear, so a decoder
  // that reports one cycle early loses nothing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_seen_r <= 1'b0;
      cmd_r <= 3'b000;
      err_r <= 1'b0;
    end else if (frame_start) begin
      cmd_seen_r <= cmd_valid_in;
      err_r <= err_any;
      if (cmd_valid_in) begin
        cmd_r <= cmd_kind_in;
      end
    end else begin
      if (cmd_valid_in) begin
        cmd_seen_r <= 1'b1;
        cmd_r <= cmd_kind_in;
      end
      if (err_any) begin
        err_r <= 1'b1; // sticky until the next frame starts
      end
    end
  end

  // response decision; a frame without a complete command counts as short
  logic [3:0] resp_r;
  logic [3:0] resp_nxt;
  logic read_pend_r;
  logic read_pend_nxt;
  logic lock_r;
  logic lock_nxt;
  cmd_resp_pkg::cmd_kind_e kind;

  always_comb begin
    kind = cmd_resp_pkg::cmd_kind_e'(cmd_r);
    resp_nxt = resp_r;
    read_pend_nxt = 1'b0;
    lock_nxt = lock_r;
    if (err_r | ~cmd_seen_r) begin
      resp_nxt = cmd_resp_pkg::RESP_ERROR;
    end else if (read_pend_r) begin
      // second frame of a read: judged once, the mark clears either way
      if (kind == cmd_resp_pkg::CMD_NOP) begin
        resp_nxt = cmd_resp_pkg::RESP_READ_DONE;
      end else begin
        resp_nxt = cmd_resp_pkg::RESP_READ_BAD;
      end
    end else begin
      // only defined codes are reachable, 0000b/0111b/1000b never
      unique case (kind)
        cmd_resp_pkg::CMD_NOP: resp_nxt = cmd_resp_pkg::RESP_NOP;
        cmd_resp_pkg::CMD_REG_READ: begin
          resp_nxt = cmd_resp_pkg::RESP_READ;
          read_pend_nxt = 1'b1;
        end
        cmd_resp_pkg::CMD_REG_WRITE: begin
          resp_nxt = cmd_resp_pkg::RESP_WRITE;
        end
        cmd_resp_pkg::CMD_LOCK: begin
          resp_nxt = cmd_resp_pkg::RESP_LOCK;
          lock_nxt = 1'b1;
        end
        cmd_resp_pkg::CMD_UNLOCK: begin
          resp_nxt = cmd_resp_pkg::RESP_UNLOCK;
          lock_nxt = 1'b0;
        end
        cmd_resp_pkg::CMD_RESET: resp_nxt = cmd_resp_pkg::RESP_RESET;
        default: resp_nxt = cmd_resp_pkg::RESP_ERROR;
      endcase
    end
  end

  // latched only at frame end so the next frame shifts a stable code
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_r <= cmd_resp_pkg::RESP_RESET_VAL;
      read_pend_r <= 1'b0;
      lock_r <= cmd_resp_pkg::LOCK_RESET_VAL;
    end else if (frame_end) begin
      resp_r <= resp_nxt;
      read_pend_r <= read_pend_nxt;
      lock_r <= lock_nxt;
    end
  end

  // assembled status upper word
  logic [cmd_resp_pkg::STATUS_W-1:0] word;
  always_comb begin
    word = {cmd_resp_pkg::STATUS_W{1'b0}};
    word[cmd_resp_pkg::FAULT_LSB +: cmd_resp_pkg::FAULT_W] = fault_bits_in;
    word[cmd_resp_pkg::RESP_MSB:cmd_resp_pkg::RESP_LSB] = resp_r;
    word[cmd_resp_pkg::LOCK_BIT] = lock_r;
    word[cmd_resp_pkg::CLOCK_BIT] = ext_clock_in;
    word[cmd_resp_pkg::MODE_BIT] = standby_in;
  end

  // snapshot at frame start; bits launched on sclk rising edges, the
  // host samples on falling edges, zeros follow after the word
  logic [cmd_resp_pkg::STATUS_W-1:0] shift_r;
  logic sdo_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= cmd_resp_pkg::SHIFT_RESET_VAL;
      sdo_r <= 1'b0;
      status_word_out <= cmd_resp_pkg::SHIFT_RESET_VAL;
    end else begin
      status_word_out <= word;
      if (frame_start) begin
        shift_r <= word;
        sdo_r <= 1'b0;
      end else if (sclk_rise) begin
        sdo_r <= shift_r[cmd_resp_pkg::STATUS_W-1];
        shift_r <= {shift_r[cmd_resp_pkg::STATUS_W-2:0], 1'b0};
      end
    end
  end

  assign sdo_out = sdo_r;
  // enable follows the synchronised select, two clocks behind the pin
  assign sdo_oe_n_out = cs_sync_r[1];
  assign locked_out = lock_r;
endmodule

// ---- testbench/cmd_resp_status_assertions.sv ----
/* port assertions for the status block, bound from the bench top;
   assumes cs held for several clocks at a time, as the host model does */
module cmd_resp_status_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic ext_clock_in,
  input wire logic standby_in,
  input wire logic sdo_oe_n_out,
  input wire logic [15:0] status_word_out,
  input wire logic locked_out
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // cs levels long enough to cross the two-flop synchroniser
  sequence s_idle; cs_n_in [*4]; endsequence
  sequence s_busy; !cs_n_in [*3]; endsequence
  a_lock_bit: assert property (
    s_idle |=> status_word_out[2] == locked_out) else $error("lock bit");
  a_lock_hold: assert property (
    !cs_n_in |=> $stable(locked_out)) else $error("lock moved");
  a_clock_bit: assert property (
    !$past(rst_in) |-> status_word_out[1] == $past(ext_clock_in))
    else $error("clock bit");
  a_mode_bit: assert property (
    !$past(rst_in) |-> status_word_out[0] == $past(standby_in))
    else $error("mode bit");
  a_no_invalid: assert property (
    !$past(rst_in) |-> !(status_word_out[6:3] inside {4'h0, 4'h7, 4'h8}))
    else $error("bad code");
  a_first_resp: assert property (
    $fell(rst_in) |=> status_word_out[6:3] == 4'h9) else $error("first");
  a_resp_hold: assert property (
    s_busy |=> $stable(status_word_out[6:3])) else $error("resp moved");
  a_oe_idle: assert property (
    s_idle |=> sdo_oe_n_out) else $error("drives idle");
  a_oe_frame: assert property (
    s_busy |=> !sdo_oe_n_out) else $error("no drive in frame");
endmodule

// ---- testbench/host_model.sv ----
/* host controller model, also standing in for the frame decoder;
   assumes frame() is called just after a rising clock edge */
module host_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic cs_n_out = 1'b1,
  output logic sclk_out = 1'b0,
  output logic valid_out = 1'b0,
  output logic [2:0] kind_out = 3'h0,
  output logic [3:0] err_out = 4'h0,
  output logic [15:0] rx_out = 16'h0000
);
  timeunit 1ns / 1ps;
  // 200 ns serial clock, resting low between frames
  task automatic frame(input logic [2:0] k, input logic v,
    input logic [3:0] e);
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < 16; i++) begin // whole word
      sclk_out <= 1'b1;
      valid_out <= i == 8 && v;
      kind_out <= i == 8 ? k : ~k;
      err_out <= i == 8 ? e : 4'h0;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
      valid_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      rx_out <= {rx_out[14:0], sdo_in}; // late sample, past the sync lag
    end
    cs_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

// ---- testbench/tb.sv ----
/* bench top: hand-picked then random frames through the host model;
   assumes the host model plays the frame decoder as well */
module tb;
  timeunit 1ns / 1ps;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ext, stb, cs_n, sclk, vld, sdo, v, lock, pend, bad, oe_n, lkd;
  logic sdo_line;
  logic [8:0] flt;
  logic [2:0] kind, k;
  logic [3:0] err, e, exp;
  logic [15:0] rx, sw;
  logic [31:0] r;
  logic [2:0] hand [9] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h1, 3'h0, 3'h4, 3'h5,
    3'h6};
  logic [3:0] codes [8] = '{4'h1, 4'h4, 4'h6, 4'h2, 4'h3, 4'hc, 4'ha, 4'ha};
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  cmd_resp_status dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .cmd_valid_in(vld), .cmd_kind_in(kind),
    .timeout_err_in(err[0]), .sclk_count_err_in(err[1]),
    .cmd_crc_err_in(err[2]), .data_crc_err_in(err[3]),
    .ext_clock_in(ext), .standby_in(stb), .fault_bits_in(flt),
    .sdo_out(sdo), .sdo_oe_n_out(oe_n), .status_word_out(sw),
    .locked_out(lkd));
  // a released line shows the inverse of its last bit, so a host that
  // samples while the select is off reads wrong bits
  assign sdo_line = oe_n ? ~sdo : sdo;
  host_model h (.clk_in(clk_in), .sdo_in(sdo_line), .cs_n_out(cs_n),
    .sclk_out(sclk), .valid_out(vld), .kind_out(kind), .err_out(err),
    .rx_out(rx));
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  // hang guard, about three and a half times the frame run
  always @(posedge clk_in) if (++cyc == 20000) begin
    fail_count++;
    give_verdict();
  end
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_checks++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: %h, expected %h", $time, got, want);
    end
  endtask
  // code due after the frame just sent, read before state moves on
  function automatic logic [3:0] next_resp();
    if (bad) return 4'ha;
    if (pend) return k == 3'h0 ? 4'h5 : 4'hb;
    return codes[k];
  endfunction
  // reset at the start and again mid-run, then one frame per pass
  initial begin
    {flt, ext, stb} = 11'h000;
    r = $urandom(32'h9768_fd26);
    for (int n = 0; n < 40; n++) begin
      if (n % 20 == 0) begin
        rst_in <= 1'b1;
        {exp, lock, pend} = {4'h9, 2'h0};
      end
      repeat (n % 20 ? 1 : 5) @(posedge clk_in);
      if (n % 20 == 0) chk(sw, 16'h0000);
      rst_in <= 1'b0;
      r = $urandom;
      k = n < 9 ? hand[n] : 3'(r[31:29] % (pend ? 6 : 8));
      v = n < 9 || r[28:26] != 3'h0;
      e = n < 9 || r[25:24] != 2'h0 ? 4'h0 : 4'h1 << r[23:22];
      {flt, ext, stb} <= r[10:0];
      h.frame(k, v, e);
      chk(rx, {r[10:2], exp, lock, r[1:0]});
      bad = !v || e != 4'h0;
      exp = next_resp();
      if (!bad && !pend && k inside {3'h3, 3'h4}) lock = k == 3'h3;
      pend = !bad && !pend && k == 3'h1;
      chk(sw, {r[10:2], exp, lock, r[1:0]});
      chk({15'h0000, lkd}, {15'h0000, lock});
    end
    give_verdict();
  end
endmodule
bind cmd_resp_status cmd_resp_status_assertions chk_i (.*);
